// File: core/arcdp_pkg.sv
// Package with register indices, field positions and enumerations of the calibration datapath.
package arcdp_pkg;

  // ==========================================================================
  // Converter channels
  typedef enum logic [2:0] {
    ARCDP_CH_TEMP,
    ARCDP_CH_VOLT,
    ARCDP_CH_BIAS,
    ARCDP_CH_TX,
    ARCDP_CH_RX
  } arcdp_chan_e;

  localparam int ARCDP_NUM_CH = 5;

  // ==========================================================================
  // Register indices; the bus byte address of an index is four times it.
  localparam logic [7:0] ARCDP_IDX_CFG_TWO = 8'h01;
  localparam logic [7:0] ARCDP_IDX_CFG_FOUR = 8'h1a;
  localparam logic [7:0] ARCDP_IDX_RXLUT = 8'h28;
  localparam logic [7:0] ARCDP_IDX_RSVD_LO = 8'h48;
  localparam logic [7:0] ARCDP_IDX_RSVD_HI = 8'h49;
  localparam logic [7:0] ARCDP_IDX_TOFF = 8'h4a;
  localparam logic [7:0] ARCDP_IDX_VSLP = 8'h4c;
  localparam logic [7:0] ARCDP_IDX_VOFF = 8'h4e;
  localparam logic [7:0] ARCDP_IDX_ISLP = 8'h50;
  localparam logic [7:0] ARCDP_IDX_IOFF = 8'h52;
  localparam logic [7:0] ARCDP_IDX_TXSLP = 8'h54;
  localparam logic [7:0] ARCDP_IDX_TXOFF = 8'h56;
  localparam logic [7:0] ARCDP_IDX_CAL_LAST = 8'h57;
  localparam logic [7:0] ARCDP_IDX_RES = 8'h60;
  localparam logic [7:0] ARCDP_IDX_RES_LAST = 8'h69;

  // RX set m: slope at RXLUT + 4m, offset at RXLUT + 4m + 2.
  localparam logic [7:0] ARCDP_RX_STRIDE = 8'h04;
  localparam logic [7:0] ARCDP_RX_OFF_GAP = 8'h02;

  // ==========================================================================
  // Fields and values
  localparam int ARCDP_CAL_MODE_BIT = 0;
  localparam int ARCDP_BIAS_POL_BIT = 0;
  localparam logic [7:0] ARCDP_CFG_RESET = 8'h00;
  localparam logic [7:0] ARCDP_MEM_RESET = 8'h00;
  localparam logic [15:0] ARCDP_RES_RESET = 16'h0000;
  localparam logic [15:0] ARCDP_UNITY_SLOPE = 16'h0100;
  localparam logic [15:0] ARCDP_ZERO_OFFSET = 16'h8000;
  localparam logic [15:0] ARCDP_TEMP_OFF_MASK = 16'hff00;
  localparam int ARCDP_FRAC_BITS = 8;

  // AHB-Lite encodings
  localparam logic [1:0] ARCDP_HTRANS_NONSEQ = 2'b10;
  localparam logic [1:0] ARCDP_HTRANS_SEQ = 2'b11;
  localparam logic ARCDP_HRESP_OKAY = 1'b0;

endpackage : arcdp_pkg

// File: core/arcdp_top.sv
// Calibration datapath between the monitor converter and the diagnostic result memory.
`timescale 1ns/10ps
module arcdp_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic adc_valid,
  input wire arcdp_pkg::arcdp_chan_e adc_channel,
  input wire logic [15:0] adc_result,
  input wire logic [2:0] rx_segment,
  output logic cal_mode_select,
  output logic bias_polarity_select,
  output logic result_stored
);
  import arcdp_pkg::*;

  // ==========================================================================
  // Storage
  logic [7:0] cfg_two_r;
  logic [7:0] cfg_four_r;
  logic [7:0] cal_mem [ARCDP_IDX_RXLUT:ARCDP_IDX_CAL_LAST];
  logic [15:0] res_mem [0:ARCDP_NUM_CH-1];

  // High byte is taken from the lower address.
  function automatic logic [15:0] fetch16(input logic [7:0] idx);
    fetch16 = {cal_mem[idx], cal_mem[idx + 8'h01]};
  endfunction

  function automatic logic in_cal(input logic [7:0] idx);
    in_cal = (idx >= ARCDP_IDX_RXLUT) && (idx <= ARCDP_IDX_CAL_LAST) &&
      (idx != ARCDP_IDX_RSVD_LO) && (idx != ARCDP_IDX_RSVD_HI);
  endfunction

  // ==========================================================================
  // AHB-Lite slave, zero wait states
  logic wr_pend_r;
  logic [7:0] wr_idx_r;
  logic wr_map_r;
  logic [31:0] hrdata_r;
  logic acc;
  logic a_map;
  logic [7:0] a_idx;
  logic [7:0] rd_byte;

  assign acc = hsel && hready && (htrans == ARCDP_HTRANS_NONSEQ || htrans == ARCDP_HTRANS_SEQ);
  assign a_idx = haddr[9:2];
  assign a_map = (haddr[31:10] == 22'h000000);
  assign hreadyout = 1'b1;
  assign hresp = ARCDP_HRESP_OKAY;
  assign hrdata = hrdata_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_idx_r <= 8'h00;
      wr_map_r <= 1'b0;
    end else if (hready) begin
      wr_pend_r <= acc && hwrite;
      wr_idx_r <= a_idx;
      wr_map_r <= a_map;
    end
  end

  always_comb begin
    rd_byte = 8'h00;
    if (a_idx == ARCDP_IDX_CFG_TWO) begin
      rd_byte = cfg_two_r;
    end else if (a_idx == ARCDP_IDX_CFG_FOUR) begin
      rd_byte = cfg_four_r;
    end else if (in_cal(a_idx)) begin
      rd_byte = cal_mem[a_idx];
    end else if (a_idx >= ARCDP_IDX_RES && a_idx <= ARCDP_IDX_RES_LAST) begin
      // Even index is the high byte of the channel word.
      rd_byte = a_idx[0] ? res_mem[3'((a_idx - ARCDP_IDX_RES) >> 1)][7:0] :
        res_mem[3'((a_idx - ARCDP_IDX_RES) >> 1)][15:8];
    end
    // A write still in its data phase to a configuration or coefficient byte is forwarded to a read of the same byte.
    if (wr_pend_r && wr_map_r && wr_idx_r == a_idx && (a_idx == ARCDP_IDX_CFG_TWO ||
        a_idx == ARCDP_IDX_CFG_FOUR || in_cal(a_idx))) begin
      rd_byte = hwdata[7:0];
    end
    if (!a_map) begin
      rd_byte = 8'h00;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h00000000;
    end else if (acc && !hwrite) begin
      hrdata_r <= {24'h000000, rd_byte};
    end
  end

  // ==========================================================================
  // Configuration registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_two_r <= ARCDP_CFG_RESET;
      cfg_four_r <= ARCDP_CFG_RESET;
    end else if (wr_pend_r && wr_map_r) begin
      if (wr_idx_r == ARCDP_IDX_CFG_TWO) begin
        cfg_two_r <= hwdata[7:0];
      end
      if (wr_idx_r == ARCDP_IDX_CFG_FOUR) begin
        cfg_four_r <= hwdata[7:0];
      end
    end
  end

  assign cal_mode_select = cfg_four_r[ARCDP_CAL_MODE_BIT];
  // The analog front end references the TX monitor input to ground or supply.
  assign bias_polarity_select = cfg_two_r[ARCDP_BIAS_POL_BIT];

  // Coefficient bytes; the host loads them before internal mode is used.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = ARCDP_IDX_RXLUT; i <= ARCDP_IDX_CAL_LAST; i++) begin
        cal_mem[i] <= ARCDP_MEM_RESET;
      end
    end else if (wr_pend_r && wr_map_r && in_cal(wr_idx_r)) begin
      cal_mem[wr_idx_r] <= hwdata[7:0];
    end
  end

  // ==========================================================================
  // Calibration arithmetic
  logic [15:0] slope;
  logic [15:0] off_raw;
  logic signed [15:0] off_val;
  logic [31:0] prod;
  logic signed [33:0] sum;
  logic [25:0] rounded;
  logic [15:0] cal_res;
  logic [15:0] store_val;
  logic [7:0] rx_base;

  assign rx_base = 8'(ARCDP_IDX_RXLUT + ARCDP_RX_STRIDE * {5'h00, rx_segment});

  always_comb begin
    slope = ARCDP_UNITY_SLOPE;
    off_raw = ARCDP_ZERO_OFFSET;
    case (adc_channel)
      ARCDP_CH_TEMP: begin
        // Unity slope keeps the sum a plain addition.
        slope = ARCDP_UNITY_SLOPE;
        off_raw = fetch16(ARCDP_IDX_TOFF) & ARCDP_TEMP_OFF_MASK;
      end
      ARCDP_CH_VOLT: begin
        slope = fetch16(ARCDP_IDX_VSLP);
        off_raw = fetch16(ARCDP_IDX_VOFF);
      end
      ARCDP_CH_BIAS: begin
        slope = fetch16(ARCDP_IDX_ISLP);
        off_raw = fetch16(ARCDP_IDX_IOFF);
      end
      ARCDP_CH_TX: begin
        slope = fetch16(ARCDP_IDX_TXSLP);
        off_raw = fetch16(ARCDP_IDX_TXOFF);
      end
      ARCDP_CH_RX: begin
        slope = fetch16(rx_base);
        off_raw = fetch16(8'(rx_base + ARCDP_RX_OFF_GAP));
      end
      default: begin
        slope = ARCDP_UNITY_SLOPE;
        off_raw = ARCDP_ZERO_OFFSET;
      end
    endcase
  end

  // Sign bit one is positive: the code is excess-32768, giving -32768 to +32767.
  assign off_val = $signed({~off_raw[15], off_raw[14:0]});
  // Slope carries eight fraction bits, so the product is 24.8 fixed point.
  assign prod = adc_result * slope;
  // Offset weight equals result weight, hence aligned above the fraction bits.
  assign sum = $signed({2'b00, prod}) +
    $signed({{10{off_val[15]}}, off_val, 8'h00});
  assign rounded = 26'(sum[33:ARCDP_FRAC_BITS]) + {25'h0000000, sum[ARCDP_FRAC_BITS-1]};

  // Out-of-range sums saturate rather than wrap, so a reading never jumps ends.
  always_comb begin
    if (sum[33]) begin
      cal_res = 16'h0000;
    end else if (rounded[25:16] != 10'h000) begin
      cal_res = 16'hffff;
    end else begin
      cal_res = rounded[15:0];
    end
  end

  always_comb begin
    if (cal_mode_select) begin
      store_val = cal_res;
    end else if (adc_channel == ARCDP_CH_TEMP || adc_channel == ARCDP_CH_VOLT) begin
      // The converter already delivers these two in diagnostic format.
      store_val = adc_result;
    end else begin
      store_val = {adc_result[15:8], 8'h00};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < ARCDP_NUM_CH; i++) begin
        res_mem[i] <= ARCDP_RES_RESET;
      end
    end else if (adc_valid && int'(adc_channel) < ARCDP_NUM_CH) begin
      res_mem[adc_channel] <= store_val;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      result_stored <= 1'b0;
    end else begin
      result_stored <= adc_valid && int'(adc_channel) < ARCDP_NUM_CH;
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_ext_bias_lowzero: assert property (adc_valid && !cal_mode_select && adc_channel == ARCDP_CH_BIAS |=>
    res_mem[ARCDP_CH_BIAS] == {$past(adc_result[15:8]), 8'h00})
    else $error("external bias result low byte not zero");

  a_ext_power_lowzero: assert property (adc_valid && !cal_mode_select &&
    (adc_channel == ARCDP_CH_TX || adc_channel == ARCDP_CH_RX) |=>
    res_mem[$past(adc_channel)][7:0] == 8'h00 && res_mem[$past(adc_channel)][15:8] == $past(adc_result[15:8]))
    else $error("external power result not in high byte");

  a_ext_volt_raw: assert property (adc_valid && !cal_mode_select && adc_channel == ARCDP_CH_VOLT |=>
    res_mem[ARCDP_CH_VOLT] == $past(adc_result))
    else $error("external voltage result altered");

  a_int_temp_add: assert property (adc_valid && cal_mode_select && adc_channel == ARCDP_CH_TEMP &&
    fetch16(ARCDP_IDX_TOFF) == 16'h8105 && adc_result < 16'hfe00 |=>
    res_mem[ARCDP_CH_TEMP] == $past(adc_result) + 16'h0100)
    else $error("temperature offset not one degree with low byte ignored");

  a_int_offset_pos: assert property (adc_valid && cal_mode_select && adc_channel == ARCDP_CH_TX &&
    fetch16(ARCDP_IDX_TXSLP) == 16'h0100 && fetch16(ARCDP_IDX_TXOFF) == 16'h8005 && adc_result < 16'hfff0 |=>
    res_mem[ARCDP_CH_TX] == $past(adc_result) + 16'h0005)
    else $error("positive offset not applied");

  a_int_offset_neg: assert property (adc_valid && cal_mode_select && adc_channel == ARCDP_CH_VOLT &&
    fetch16(ARCDP_IDX_VSLP) == 16'h0100 && fetch16(ARCDP_IDX_VOFF) == 16'h7ffd && adc_result > 16'h0010 |=>
    res_mem[ARCDP_CH_VOLT] == $past(adc_result) - 16'h0003)
    else $error("negative offset not applied");

  a_int_round_half: assert property (adc_valid && cal_mode_select && adc_channel == ARCDP_CH_BIAS &&
    fetch16(ARCDP_IDX_ISLP) == 16'h0080 && fetch16(ARCDP_IDX_IOFF) == 16'h8000 && adc_result[0] |=>
    res_mem[ARCDP_CH_BIAS] == ($past(adc_result) >> 1) + 16'h0001)
    else $error("half slope result not rounded up");

  a_rx_segment: assert property (adc_valid && cal_mode_select && adc_channel == ARCDP_CH_RX &&
    fetch16(rx_base) == 16'h0200 && fetch16(8'(rx_base + ARCDP_RX_OFF_GAP)) == 16'h8000 &&
    adc_result < 16'h8000 |=> res_mem[ARCDP_CH_RX] == {$past(adc_result[14:0]), 1'b0})
    else $error("rx segment coefficients not used");

  a_mode_write: assert property (wr_pend_r && wr_map_r && wr_idx_r == ARCDP_IDX_CFG_FOUR |=>
    cal_mode_select == $past(hwdata[ARCDP_CAL_MODE_BIT]))
    else $error("calibration mode bit not written");

  a_stored_pulse: assert property (adc_valid && int'(adc_channel) < ARCDP_NUM_CH |=> result_stored)
    else $error("store pulse missing");

  c_int_rx: cover property (adc_valid && cal_mode_select && adc_channel == ARCDP_CH_RX && rx_segment == 3'h7);
  c_ext_bias: cover property (adc_valid && !cal_mode_select && adc_channel == ARCDP_CH_BIAS);
  c_saturate: cover property (adc_valid && cal_mode_select && sum[33]);
  c_fwd_read: cover property (wr_pend_r && acc && !hwrite && a_idx == wr_idx_r);

endmodule // arcdp_top

// File: sim/arcdp_host.sv
// Host model: an AHB-Lite master that reaches the byte-wide calibration registers.
`timescale 1ns/10ps
module arcdp_host (
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  import arcdp_pkg::*;
  initial begin
    hsel = 1'b1;
    haddr = 32'h00000000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
  end
  // =========================================================================
  // Bus cycles
  // The write data line is inverted during the address phase so a stale value never passes.
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d, output logic [7:0] q);
    htrans <= ARCDP_HTRANS_NONSEQ;
    haddr <= {22'h000000, idx, 2'b00};
    hwrite <= w;
    hwdata <= ~hwdata;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= {24'h000000, d};
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    q = hrdata[7:0];
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] q;
    xfer(1'b1, idx, d, q);
  endtask
  task automatic rd(input logic [7:0] idx, output logic [7:0] q);
    xfer(1'b0, idx, 8'h00, q);
  endtask
  task automatic wr16(input logic [7:0] idx, input logic [15:0] v);
    wr(idx, v[15:8]);
    wr(idx + 8'h01, v[7:0]);
  endtask
  task automatic rd16(input logic [7:0] idx, output logic [15:0] v);
    rd(idx, v[15:8]);
    rd(idx + 8'h01, v[7:0]);
  endtask
endmodule // arcdp_host

// File: sim/test_adc_result_calibration_datapath.sv
// Self-checking bench for the calibration datapath.
`timescale 1ns/10ps
module test_adc_result_calibration_datapath;
  import arcdp_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic adc_valid = 1'b0;
  arcdp_chan_e adc_channel = ARCDP_CH_TEMP;
  logic [15:0] adc_result = 16'h0000;
  logic [2:0] rx_segment = 3'h0;
  logic hsel, hwrite, hreadyout, hresp, cal_mode_select, bias_polarity_select, result_stored;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  int err_total = 0;
  int compares = 0;
  always #10 hclk = ~hclk;
  arcdp_host host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  arcdp_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .adc_valid(adc_valid), .adc_channel(adc_channel),
    .adc_result(adc_result), .rx_segment(rx_segment), .cal_mode_select(cal_mode_select),
    .bias_polarity_select(bias_polarity_select), .result_stored(result_stored));
  // =========================================================================
  // Helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Offsets are excess-32768 at result weight; out-of-range sums clamp to the rails.
  function automatic logic [15:0] cal(input logic [15:0] a, input logic [15:0] s, input logic [15:0] o);
    logic signed [40:0] x;
    x = $signed({25'h0, a}) * $signed({25'h0, s}) + ($signed({25'h0, o}) - 41'sd32768) * 41'sd256;
    x = (x >>> 8) + $signed({40'h0, x[7]});
    if (x < 0) return 16'h0000;
    if (x > 41'sd65535) return 16'hffff;
    return x[15:0];
  endfunction
  function automatic logic [7:0] ridx(input arcdp_chan_e c);
    return ARCDP_IDX_RES + {4'h0, c, 1'b0};
  endfunction
  // The result line is inverted once the strobe drops, as a converter would leave it undefined.
  task automatic conv(input arcdp_chan_e c, input logic [15:0] a, input logic [2:0] m);
    adc_valid <= 1'b1;
    adc_channel <= c;
    adc_result <= a;
    rx_segment <= m;
    @(posedge hclk);
    adc_valid <= 1'b0;
    adc_result <= ~a;
    #1 chk({15'h0, result_stored}, {15'h0, c < ARCDP_NUM_CH});
    @(posedge hclk);
  endtask
  // =========================================================================
  // Scenarios
  task automatic t_reset();
    logic [7:0] b;
    logic [15:0] v;
    host.rd(ARCDP_IDX_CFG_FOUR, b);
    chk({8'h00, b}, {8'h00, ARCDP_CFG_RESET});
    chk({15'h0, cal_mode_select}, 16'h0000);
    chk({15'h0, hresp}, {15'h0, ARCDP_HRESP_OKAY});
    host.rd16(ARCDP_IDX_RES, v);
    chk(v, ARCDP_RES_RESET);
  endtask
  task automatic t_ext();
    logic [15:0] v, a;
    logic [7:0] b;
    host.wr16(ARCDP_IDX_VSLP, ARCDP_UNITY_SLOPE);
    host.wr16(ARCDP_IDX_VOFF, ARCDP_ZERO_OFFSET);
    for (int c = 0; c < ARCDP_NUM_CH; c++) begin
      a = 16'h12ab + 16'(c * 16'h1111);
      conv(arcdp_chan_e'(c), a, 3'h5);
      host.rd16(ridx(arcdp_chan_e'(c)), v);
      chk(v, (c < 2) ? a : {a[15:8], 8'h00});
    end
    host.rd(ridx(ARCDP_CH_TX), b);
    chk({8'h00, b}, 16'h0045);
    conv(arcdp_chan_e'(3'd5), 16'hffff, 3'h0);
    host.rd16(ridx(ARCDP_CH_VOLT), v);
    chk(v, 16'h23bc);
  endtask
  task automatic t_cfg();
    logic [7:0] b;
    host.wr(ARCDP_IDX_CFG_TWO, 8'h01);
    host.wr(ARCDP_IDX_CFG_FOUR, 8'h01);
    host.rd(ARCDP_IDX_CFG_FOUR, b);
    chk({8'h00, b}, 16'h0001);
    chk({14'h0, cal_mode_select, bias_polarity_select}, 16'h0003);
    host.wr(ARCDP_IDX_RSVD_LO, 8'h5a);
    host.rd(ARCDP_IDX_RSVD_LO, b);
    chk({8'h00, b}, 16'h0000);
    host.wr(ARCDP_IDX_RES, 8'h77);
    host.rd(ARCDP_IDX_RES, b);
    chk({8'h00, b}, 16'h0012);
  endtask
  task automatic t_int();
    arcdp_chan_e ch[9] = '{ARCDP_CH_TEMP, ARCDP_CH_VOLT, ARCDP_CH_BIAS, ARCDP_CH_TX, ARCDP_CH_VOLT,
      ARCDP_CH_TEMP, ARCDP_CH_VOLT, ARCDP_CH_BIAS, ARCDP_CH_TX};
    logic [7:0] si[9] = '{ARCDP_IDX_TOFF, ARCDP_IDX_VSLP, ARCDP_IDX_ISLP, ARCDP_IDX_TXSLP, ARCDP_IDX_VSLP,
      ARCDP_IDX_TOFF, ARCDP_IDX_VSLP, ARCDP_IDX_ISLP, ARCDP_IDX_TXSLP};
    logic [15:0] sl[9] = '{16'h0100, 16'h0180, 16'h0001, 16'h0200, 16'h0100, 16'h0100, 16'h0100, 16'h0080,
      16'h0100};
    logic [15:0] of[9] = '{16'h8312, 16'h8005, 16'h7ffd, 16'h8000, 16'h0000, 16'h8105, 16'h7ffd, 16'h8000,
      16'h8005};
    logic [15:0] ad[9] = '{16'h1900, 16'h0101, 16'h1000, 16'hff00, 16'h0010, 16'h1900, 16'h0101, 16'h1001,
      16'h1234};
    logic [15:0] v, e;
    for (int i = 0; i < 9; i++) begin
      if (ch[i] == ARCDP_CH_TEMP) host.wr16(si[i], of[i]);
      else begin
        host.wr16(si[i], sl[i]);
        host.wr16(si[i] + ARCDP_RX_OFF_GAP, of[i]);
      end
      e = cal(ad[i], sl[i], (ch[i] == ARCDP_CH_TEMP) ? (of[i] & ARCDP_TEMP_OFF_MASK) : of[i]);
      conv(ch[i], ad[i], 3'h0);
      host.rd16(ridx(ch[i]), v);
      chk(v, e);
    end
    // Zero-current bias reading with neutral constants, then its negation stored as the offset.
    host.wr16(ARCDP_IDX_ISLP, ARCDP_UNITY_SLOPE);
    host.wr16(ARCDP_IDX_IOFF, ARCDP_ZERO_OFFSET);
    conv(ARCDP_CH_BIAS, 16'h0042, 3'h0);
    host.rd16(ridx(ARCDP_CH_BIAS), v);
    chk(v, 16'h0042);
    host.wr16(ARCDP_IDX_IOFF, ARCDP_ZERO_OFFSET - 16'h0042);
    conv(ARCDP_CH_BIAS, 16'h0042, 3'h0);
    host.rd16(ridx(ARCDP_CH_BIAS), v);
    chk(v, 16'h0000);
  endtask
  task automatic t_rx();
    logic [15:0] v;
    for (int m = 0; m < 8; m++) begin
      host.wr16(ARCDP_IDX_RXLUT + ARCDP_RX_STRIDE * 8'(m), 16'(16'h0100 + 16 * m));
      host.wr16(ARCDP_IDX_RXLUT + ARCDP_RX_STRIDE * 8'(m) + ARCDP_RX_OFF_GAP, 16'(16'h8000 + 3 * m));
    end
    for (int m = 7; m >= 0; m--) begin
      conv(ARCDP_CH_RX, 16'h0840, 3'(m));
      host.rd16(ridx(ARCDP_CH_RX), v);
      chk(v, cal(16'h0840, 16'(16'h0100 + 16 * m), 16'(16'h8000 + 3 * m)));
    end
    host.wr16(ARCDP_IDX_RXLUT + ARCDP_RX_STRIDE * 8'h02, 16'h0200);
    host.wr16(ARCDP_IDX_RXLUT + ARCDP_RX_STRIDE * 8'h02 + ARCDP_RX_OFF_GAP, ARCDP_ZERO_OFFSET);
    conv(ARCDP_CH_RX, 16'h0840, 3'h2);
    host.rd16(ridx(ARCDP_CH_RX), v);
    chk(v, 16'h1080);
  endtask
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_ext();
    t_cfg();
    t_int();
    t_rx();
    end_sim();
  end
  // The tests need well under a thousand cycles; this limit leaves a wide margin.
  initial begin
    #100000;
    err_total++;
    end_sim();
  end
endmodule // test_adc_result_calibration_datapath
